// ==== core/dscp_pkg.sv ====
package dscp_pkg;

  // ****************************************
  // instruction byte layout
  // ****************************************
  localparam int        BYTE_W        = 8;
  localparam logic [2:0] BIT_LAST     = 3'h7;
  localparam int        INSTR_RW_BIT  = 7;
  localparam int        CNT_HI_BIT    = 6;
  localparam int        CNT_LO_BIT    = 5;
  localparam int        ADDR_HI_BIT   = 4;
  localparam logic       DIR_READ     = 1'b1;

  // ****************************************
  // address space and port configuration
  // ****************************************
  localparam logic [4:0] ADDR_MIN      = 5'h00;
  localparam logic [4:0] ADDR_MAX      = 5'h1F;
  localparam logic [4:0] CFG_ADDR      = 5'h00;
  localparam int         CFG_ORDER_BIT = 6;
  localparam logic       ORDER_RESET   = 1'b0;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ       = 250;
  localparam int SCLK_MAX_MHZ  = 20;
  // shortest serial clock half period in system clocks, rounded down
  localparam int SCLK_HALF_CYC = CLK_MHZ / (2 * SCLK_MAX_MHZ);
  localparam int SYNC_STAGES   = 2;

  typedef enum logic [1:0] {DSCP_INSTR, DSCP_DATA, DSCP_DONE} dscp_state_t;

endpackage : dscp_pkg

// ==== core/dscp_sync.sv ====
`timescale 1ns/1ps

// ****************************************
// pin synchroniser
// ****************************************
module dscp_sync #(
  parameter int WIDTH  = 4,
  parameter int STAGES = 2
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_reg [STAGES];

  // refused at elaboration, not at run time
  if (STAGES < 2 || WIDTH < 1) begin : g_bad_cfg
    $error("dscp_sync: needs two stages and one bit at least");
  end

  // first stage feeds only the next stage
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_reg[i] <= '0;
      end
    end else begin
      stage_reg[0] <= async_in;
      for (int i = 1; i < STAGES; i++) begin
        stage_reg[i] <= stage_reg[i-1];
      end
    end
  end

  assign sync_out = stage_reg[STAGES-1];

endmodule : dscp_sync

// ==== core/dscp_port.sv ====
`timescale 1ns/1ps
module dscp_port
  import dscp_pkg::*;
#(
  parameter int ADDR_W = 5
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // serial pins
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              sdio_in,
  output logic                   sdio_out,
  output logic                   sdio_oe,
  input  wire logic              port_reset_strap_pin,
  // register file side
  output logic                   cfg_wr_pulse,
  output logic      [ADDR_W-1:0] cfg_waddr,
  output logic      [BYTE_W-1:0] cfg_wdata,
  output logic      [ADDR_W-1:0] cfg_raddr,
  input  wire logic [BYTE_W-1:0] cfg_rdata,
  // status
  output logic                   bit_order_select
);

  // ****************************************
  // checks and synchronisers
  // ****************************************
  // refused at elaboration, not at run time
  if (ADDR_W != 5 || SCLK_HALF_CYC < SYNC_STAGES + 2) begin : g_bad_cfg
    $error("dscp_port: address width or clock ratio not supported");
  end

  logic [3:0]        pins_s;
  logic              sclk_s;
  logic              cs_s;
  logic              sdio_s;
  logic              strap_s;
  logic              sclk_d_reg;
  logic              rise;
  logic              fall;
  logic              active;
  dscp_state_t       state_reg;
  logic [2:0]        bit_cnt_reg;
  logic [1:0]        left_reg;
  logic              read_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;
  logic [BYTE_W-1:0] rx_reg;
  logic [BYTE_W-1:0] rx_next;
  logic [BYTE_W-1:0] tx_reg;
  logic              order_reg;
  logic              out_reg;
  logic              wr_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [BYTE_W-1:0] wdata_reg;
  logic              byte_end;
  logic              instr_end;

  dscp_sync #(
    .WIDTH  (4),
    .STAGES (SYNC_STAGES)
  ) u_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in ({port_reset_strap_pin, sdio_in, cs_n, sclk}),
    .sync_out (pins_s)
  );

  assign {strap_s, sdio_s, cs_s, sclk_s} = pins_s;

  always_ff @(posedge clk) begin
    if (reset) begin
      sclk_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_s;
    end
  end

  // ****************************************
  // edges and shift helpers
  // ****************************************
  // edge choice
  assign rise     = sclk_s & ~sclk_d_reg;
  assign fall     = ~sclk_s & sclk_d_reg;
  // cycle gating, strap also holds the port idle
  assign active   = ~cs_s & ~strap_s;
  assign byte_end = active & rise & (bit_cnt_reg == BIT_LAST);
  assign instr_end = byte_end & (state_reg == DSCP_INSTR);
  assign rx_next  = order_reg ? {sdio_s, rx_reg[BYTE_W-1:1]}
                              : {rx_reg[BYTE_W-2:0], sdio_s};

  always_comb begin
    addr_next = addr_reg;
    if (order_reg) begin
      if (addr_reg != ADDR_MAX) addr_next = addr_reg + 5'h01;
    end else begin
      if (addr_reg != ADDR_MIN) addr_next = addr_reg - 5'h01;
    end
  end

  // ****************************************
  // cycle sequencing
  // ****************************************
  // leaving the cycle restarts the instruction phase
  always_ff @(posedge clk) begin
    if (reset || !active) begin
      state_reg   <= DSCP_INSTR;
      bit_cnt_reg <= 3'h0;
      left_reg    <= 2'h0;
      read_reg    <= 1'b0;
      addr_reg    <= ADDR_MIN;
      rx_reg      <= 8'h00;
    end else if (rise) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      unique case (state_reg)
        DSCP_INSTR: begin
          rx_reg <= rx_next;
          if (bit_cnt_reg == BIT_LAST) begin
            state_reg <= DSCP_DATA;
            read_reg  <= rx_next[INSTR_RW_BIT];
            left_reg  <= rx_next[CNT_HI_BIT:CNT_LO_BIT];
            addr_reg  <= rx_next[ADDR_HI_BIT:0];
          end
        end
        DSCP_DATA: begin
          rx_reg <= rx_next;
          if (bit_cnt_reg == BIT_LAST) begin
            if (left_reg == 2'h0) begin
              state_reg <= DSCP_DONE;
            end else begin
              left_reg <= left_reg - 2'h1;
              addr_reg <= addr_next;
            end
          end
        end
        DSCP_DONE: begin
          rx_reg <= rx_reg;
        end
      endcase
    end
  end

  // ****************************************
  // write commit
  // ****************************************
  // commit per byte, only whole bytes reach here
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_reg    <= 1'b0;
      waddr_reg <= ADDR_MIN;
      wdata_reg <= 8'h00;
    end else begin
      wr_reg <= byte_end && state_reg == DSCP_DATA && !read_reg;
      if (byte_end && state_reg == DSCP_DATA && !read_reg) begin
        waddr_reg <= addr_reg;
        wdata_reg <= rx_next;
      end
    end
  end

  // local copy of the bit order, changes as soon as its byte lands
  always_ff @(posedge clk) begin
    if (reset) begin
      order_reg <= ORDER_RESET;
    end else if (byte_end && state_reg == DSCP_DATA && !read_reg
                 && addr_reg == CFG_ADDR) begin
      order_reg <= rx_next[CFG_ORDER_BIT];
    end
  end

  // ****************************************
  // read shifting
  // ****************************************
  // output bits change on falling edges; read data must settle
  // within one system clock of cfg_raddr, well inside a half period
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_reg  <= 8'h00;
      out_reg <= 1'b0;
    end else if (active && fall && state_reg == DSCP_DATA && read_reg) begin
      if (bit_cnt_reg == 3'h0) begin
        tx_reg  <= cfg_rdata;
        out_reg <= order_reg ? cfg_rdata[0] : cfg_rdata[BYTE_W-1];
      end else begin
        tx_reg  <= order_reg ? (tx_reg >> 1) : (tx_reg << 1);
        out_reg <= order_reg ? tx_reg[1] : tx_reg[BYTE_W-2];
      end
    end
  end

  // one pin, driven only while reading data
  assign sdio_oe          = active && state_reg == DSCP_DATA && read_reg;
  assign sdio_out         = out_reg;
  // every address reachable for both directions
  assign cfg_raddr        = addr_reg;
  assign cfg_wr_pulse     = wr_reg;
  assign cfg_waddr        = waddr_reg;
  assign cfg_wdata        = wdata_reg;
  assign bit_order_select = order_reg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking dscp_cb @(posedge clk); endclocking
  default disable iff (reset);

  cs_idle_a : assert property (cs_s |=> state_reg == DSCP_INSTR && bit_cnt_reg == 3'h0)
    else $error("cycle not ended by chip select");
  pin_release_a : assert property (cs_s |-> !sdio_oe)
    else $error("data pin driven while deselected");
  strap_clear_a : assert property (strap_s |=> state_reg == DSCP_INSTR && bit_cnt_reg == 3'h0)
    else $error("strap pulse did not restart sequencing");
  strap_nowrite_a : assert property (strap_s ##1 strap_s |-> !cfg_wr_pulse)
    else $error("write committed during strap pulse");
  instr_decode_a : assert property (byte_end && state_reg == DSCP_INSTR |=>
      state_reg == DSCP_DATA && read_reg == $past(rx_next[7])
      && left_reg == $past(rx_next[6:5]) && addr_reg == $past(rx_next[4:0]))
    else $error("instruction byte decoded wrongly");
  byte_commit_a : assert property (byte_end && state_reg == DSCP_DATA && !read_reg |=>
      cfg_wr_pulse && cfg_wdata == $past(rx_next) && cfg_waddr == $past(addr_reg))
    else $error("written byte not committed at its last bit");
  addr_down_a : assert property (byte_end && state_reg == DSCP_DATA && left_reg != 2'h0
      && !order_reg && addr_reg != ADDR_MIN |=> addr_reg == $past(addr_reg) - 5'h01)
    else $error("msb first address did not decrement");
  addr_up_a : assert property (byte_end && state_reg == DSCP_DATA && left_reg != 2'h0
      && order_reg && addr_reg != ADDR_MAX |=> addr_reg == $past(addr_reg) + 5'h01)
    else $error("lsb first address did not increment");
  drive_read_a : assert property ($rose(sdio_oe) |-> $past(instr_end))
    else $error("data pin driven before the instruction byte ended");
  last_byte_a : assert property (byte_end && state_reg == DSCP_DATA && left_reg == 2'h0
      |=> state_reg == DSCP_DONE ##1 !sdio_oe)
    else $error("transfer ran past its byte count");

  read_cov : cover property (byte_end && state_reg == DSCP_DATA && read_reg);
  multi_write_cov : cover property (wr_reg && left_reg == 2'h2);
  order_flip_cov : cover property (!order_reg ##1 order_reg);
  strap_mid_cov : cover property (strap_s && state_reg == DSCP_DATA);

endmodule : dscp_port

// ==== tb/dscp_host.sv ====
`timescale 1ns/1ps

// ****************************************
// serial host model
// ****************************************
module dscp_host (
  // clock
  input  wire logic clk,
  // serial pins
  output logic      sclk,
  output logic      cs_n,
  output logic      host_d,
  output logic      host_en,
  input  wire logic sdio
);
  initial begin
    sclk    = 1'b0;
    cs_n    = 1'b1;
    host_d  = 1'b0;
    host_en = 1'b0;
  end

  // select gates the frame
  // serial clock stands low outside frames
  task automatic sel(input logic on);
    @(posedge clk);
    cs_n    <= ~on;
    host_en <= 1'b0;
    repeat (8) @(posedge clk);
    sclk <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : sel

  // fall then rise
  // nb below eight leaves a partial byte on purpose
  task automatic xbyte(input logic [7:0] tx, input logic lsb, input logic drv,
                       input int nb, output logic [7:0] rx);
    int idx;
    rx = 8'h00;
    for (int i = 0; i < nb; i++) begin
      idx = lsb ? i : 7 - i;
      @(posedge clk);
      sclk    <= 1'b0;
      host_d  <= tx[idx];
      host_en <= drv;
      repeat (8) @(posedge clk);
      sclk <= 1'b1;
      rx[idx] = sdio;
      repeat (7) @(posedge clk);
    end
  endtask : xbyte
endmodule : dscp_host

// ==== tb/dscp_port_tb.sv ====
`timescale 1ns/1ps

// ****************************************
// bench top
// ****************************************
module dscp_port_tb;
  import dscp_pkg::*;
  logic       clk;
  logic       reset;
  logic       strap;
  logic       sclk, cs_n, host_d, host_en, sdio, sdio_out, sdio_oe;
  logic       cfg_wr_pulse, bit_order_select;
  logic [4:0] cfg_waddr, cfg_raddr;
  logic [7:0] cfg_wdata, rx;
  logic [7:0] cfg_rdata;
  logic [7:0] mem [32];
  logic [31:0] r;
  int         n_errors = 0;
  int         cmp_count = 0;
  int         n_wr = 0;

  always #2 clk = ~clk;

  // one shared pin
  // released line shows the inverse so stale values never pass
  assign sdio = sdio_oe ? sdio_out : (host_en ? host_d : ~host_d);

  always @(posedge clk) begin
    if (cfg_wr_pulse) begin
      mem[cfg_waddr] <= cfg_wdata;
      n_wr <= n_wr + 1;
    end
    cfg_rdata <= mem[cfg_raddr];
  end

  dscp_host host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .host_d(host_d),
                  .host_en(host_en), .sdio(sdio));

  dscp_port #(.ADDR_W(5)) dut (
    .clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .port_reset_strap_pin(strap),
    .cfg_wr_pulse(cfg_wr_pulse), .cfg_waddr(cfg_waddr), .cfg_wdata(cfg_wdata),
    .cfg_raddr(cfg_raddr), .cfg_rdata(cfg_rdata), .bit_order_select(bit_order_select));

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic test_done();
    if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done

  // one whole frame: instruction then counted bytes
  task automatic frame(input logic [7:0] ins, input logic [31:0] d, input logic lsb);
    int n;
    n = int'(ins[6:5]) + 1;
    r = 32'h0;
    host.sel(1'b1);
    host.xbyte(ins, lsb, 1'b1, 8, rx);
    for (int k = 0; k < n; k++) begin
      host.xbyte(d[8*k +: 8], lsb, ~ins[7], 8, rx);
      r[8*k +: 8] = rx;
    end
    host.sel(1'b0);
  endtask : frame

  task automatic t_write4();
    frame(8'h67, 32'h4433_2211, 1'b0);
    cmp(8'(n_wr), 8'h04);
    cmp(mem[7], 8'h11);
    cmp(mem[6], 8'h22);
    cmp(mem[4], 8'h44);
  endtask : t_write4

  task automatic t_read3();
    frame(8'hC2, 32'h0, 1'b0);
    cmp(r[7:0], 8'h42);
    cmp(r[15:8], 8'h41);
    cmp(r[23:16], 8'h00);
    cmp(8'(n_wr), 8'h04);
    cmp({7'h00, sdio_oe}, 8'h00);
    // address stops at the bottom instead of wrapping to the top register
    frame(8'hC1, 32'h0, 1'b0);
    cmp(r[23:16], 8'h00);
  endtask : t_read3

  task automatic t_lsb();
    frame(8'h00, 32'h40, 1'b0);
    cmp({7'h00, bit_order_select}, 8'h01);
    frame(8'h3E, 32'hBBAA, 1'b1);
    cmp(mem[5'h1E], 8'hAA);
    cmp(mem[5'h1F], 8'hBB);
    frame(8'h9E, 32'h0, 1'b1);
    cmp(r[7:0], 8'hAA);
    frame(8'h00, 32'h00, 1'b1);
    cmp({7'h00, bit_order_select}, 8'h00);
  endtask : t_lsb

  task automatic t_cut();
    int w0;
    w0 = n_wr;
    host.sel(1'b1);
    host.xbyte(8'h0A, 1'b0, 1'b1, 8, rx);
    host.xbyte(8'hFF, 1'b0, 1'b1, 5, rx);
    host.sel(1'b0);
    host.sel(1'b1);
    host.xbyte(8'h0A, 1'b0, 1'b1, 8, rx);
    host.xbyte(8'hFF, 1'b0, 1'b1, 6, rx);
    @(posedge clk);
    strap <= 1'b1;
    repeat (8) @(posedge clk);
    strap <= 1'b0;
    repeat (8) @(posedge clk);
    host.xbyte(8'h0B, 1'b0, 1'b1, 8, rx);
    host.xbyte(8'h5A, 1'b0, 1'b1, 8, rx);
    host.sel(1'b0);
    cmp(8'(n_wr - w0), 8'h01);
    cmp(mem[5'h0A], 8'h4A);
    cmp(mem[5'h0B], 8'h5A);
  endtask : t_cut

  initial begin
    clk   = 1'b0;
    reset = 1'b1;
    strap = 1'b0;
    foreach (mem[i]) mem[i] = (i == 0) ? 8'h00 : 8'(8'h40 + i);
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    t_write4();
    t_read3();
    t_lsb();
    t_cut();
    test_done();
  end

  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    test_done();
  end
endmodule : dscp_port_tb
